// >>> logic/ref_clock_out_routing.sv
// Purpose: Routes the synthesizer reference, its repeat output and the C/D status pins.
// Assumes: Reference inputs and samples are synchronous to ref_clk and sampled as levels.
// Notes: All outputs are registered; clock copies lag their source by one cycle.
//
// Overview of operation
// - Channel D flag high while input exceeds threshold.
// - Flags stay high for programmed minimum hold.
// - Pins low or disabled: D carries flag.
// - Any strap pin high: D undivided reference copy.
// - D halves or quarters only by register override.
// - D clocks only while C also clocks.
// - Power-down stops repeat output and pin clocks.
// - Synthesizer enable turns the synthesizer on.
// - Select high picks single-ended reference, low differential.
// - Synthesizer off: sampling uses differential input only.
// - Repeat output copies selected reference when enabled.
// - C configuration 1,2,3 gives divide 1,2,4.
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ref_clock_out_routing
    import clkout_routing_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic diff_ref_in,
    input wire logic single_ended_ref_in,
    input wire logic ref_select_pin,
    input wire logic synth_enable_pin,
    input wire logic power_down_pin,
    input wire logic [1:0] clkout_cfg_pins,
    input wire logic [SAMPLE_W-1:0] sample_c,
    input wire logic [SAMPLE_W-1:0] sample_d,
    output logic status_out_c,
    output logic status_out_d,
    output logic ref_repeat_out,
    output logic synth_active,
    output logic synth_ref_single_ended
);

    // ==========================================================================
    // State
    // ==========================================================================
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [SAMPLE_W-1:0] overrange_threshold;
        logic [HOLD_W-1:0] overrange_min_hold;
        logic wait_req;
        logic [DATA_W-1:0] rdata;
        logic ref_prev;
        logic div2;
        logic [1:0] div4;
        pin_mode_t [CHANNELS-1:0] mode;
        logic [CHANNELS-1:0] flag;
        logic [CHANNELS-1:0][HOLD_W-1:0] hold_cnt;
        logic [CHANNELS-1:0] pin_out;
        logic ref_out;
        logic synth_on;
        logic ref_se;
    } state_t;

    state_t st;
    state_t nx;

    logic [CHANNELS-1:0][SAMPLE_W-1:0] samples;
    logic [CHANNELS-1:0] exceed;
    logic sel_ref;
    logic clocks_on;
    logic [1:0] cfg_c_eff;
    pin_mode_t [CHANNELS-1:0] target;
    logic [DATA_W-1:0] read_mux;

    assign samples = {sample_d, sample_c};

    genvar g;
    for (g = 0; g < CHANNELS; g++) begin : g_cmp
        assign exceed[g] = samples[g] > st.overrange_threshold;
    end

    // Clock level that a pin would show in the given mode, from next-cycle divider state.
    function automatic logic src_of(input pin_mode_t m, input logic r, input logic d2,
                                    input logic d4);
        case (m)
            MODE_DIV1: src_of = r;
            MODE_DIV2: src_of = d2;
            MODE_DIV4: src_of = d4;
            default: src_of = 1'b0;
        endcase
    endfunction

    // ==========================================================================
    // Routing decisions
    // ==========================================================================
    always_comb begin
        // The single-ended input can be selected only while the synthesizer is enabled.
        sel_ref = (synth_enable_pin && ref_select_pin) ? single_ended_ref_in
                                                        : diff_ref_in;
        clocks_on = synth_enable_pin && !power_down_pin;
        if (st.ctrl[CTRL_DISABLE_BIT]) begin
            cfg_c_eff = 2'b00;
        end else if (st.ctrl[CTRL_OVERRIDE_BIT]) begin
            cfg_c_eff = st.ctrl[CTRL_CFG_C_LSB +: 2];
        end else begin
            cfg_c_eff = clkout_cfg_pins;
        end
        target[CH_C] = clocks_on ? pin_mode_t'(cfg_c_eff) : MODE_FLAG;
        if (!clocks_on || cfg_c_eff == 2'b00) begin
            target[CH_D] = MODE_FLAG;
        end else if (st.ctrl[CTRL_OVERRIDE_BIT]) begin
            target[CH_D] = pin_mode_t'(st.ctrl[CTRL_CFG_D_LSB +: 2]);
        end else begin
            target[CH_D] = (clkout_cfg_pins != 2'b00) ? MODE_DIV1 : MODE_FLAG;
        end
        case (avs_address)
            ADDR_CTRL: read_mux = {{(DATA_W-CTRL_W){1'b0}}, st.ctrl};
            ADDR_THRESH: read_mux = {{(DATA_W-SAMPLE_W){1'b0}}, st.overrange_threshold};
            ADDR_HOLD: read_mux = {{(DATA_W-HOLD_W){1'b0}}, st.overrange_min_hold};
            ADDR_STATUS: begin
                read_mux = RDATA_RESET;
                read_mux[STAT_FLAG_LSB +: CHANNELS] = st.flag;
                read_mux[STAT_MODE_C_LSB +: 2] = st.mode[CH_C];
                read_mux[STAT_MODE_D_LSB +: 2] = st.mode[CH_D];
                read_mux[STAT_PLL_BIT] = st.synth_on;
            end
            default: read_mux = RDATA_RESET;
        endcase
    end

    // ==========================================================================
    // Next state
    // ==========================================================================
    always_comb begin
        nx = st;
        if (ce) begin
            // One wait cycle per access; the answer stands at the edge that ends it.
            if (st.wait_req) begin
                if (avs_read || avs_write) begin
                    nx.wait_req = 1'b0;
                    nx.rdata = read_mux;
                end
            end else begin
                nx.wait_req = 1'b1;
                if (avs_write) begin
                    case (avs_address)
                        ADDR_CTRL: nx.ctrl = avs_writedata[CTRL_W-1:0];
                        ADDR_THRESH: nx.overrange_threshold = avs_writedata[SAMPLE_W-1:0];
                        ADDR_HOLD: nx.overrange_min_hold = avs_writedata[HOLD_W-1:0];
                        default: nx.ctrl = st.ctrl;
                    endcase
                end
            end

            nx.ref_prev = sel_ref;
            if (sel_ref && !st.ref_prev) begin
                nx.div2 = !st.div2;
                nx.div4 = st.div4 + 2'b01;
            end

            for (int i = 0; i < CHANNELS; i++) begin
                if (power_down_pin) begin
                    nx.flag[i] = 1'b0;
                    nx.hold_cnt[i] = '0;
                end else if (exceed[i]) begin
                    nx.flag[i] = 1'b1;
                    nx.hold_cnt[i] = st.overrange_min_hold;
                end else if (st.hold_cnt[i] > HOLD_W'(1)) begin
                    nx.hold_cnt[i] = st.hold_cnt[i] - HOLD_W'(1);
                end else begin
                    nx.flag[i] = 1'b0;
                    nx.hold_cnt[i] = '0;
                end
            end

            // A pin changes source only while it is low and, unless it goes to the flag, the new source is low too,
            // so no shortened high or low phase ever reaches the board.
            for (int i = 0; i < CHANNELS; i++) begin
                if (target[i] != st.mode[i] && !st.pin_out[i] &&
                    (target[i] == MODE_FLAG ||
                     !src_of(target[i], sel_ref, nx.div2, nx.div4[1]))) begin
                    if (i == CH_D && target[i] != MODE_FLAG) begin
                        if (st.mode[CH_C] != MODE_FLAG) begin
                            nx.mode[i] = target[i];
                        end
                    end else if (i == CH_C && target[i] == MODE_FLAG) begin
                        if (st.mode[CH_D] == MODE_FLAG) begin
                            nx.mode[i] = target[i];
                        end
                    end else begin
                        nx.mode[i] = target[i];
                    end
                end
            end

            for (int i = 0; i < CHANNELS; i++) begin
                if (power_down_pin) begin
                    nx.pin_out[i] = 1'b0;
                end else if (nx.mode[i] == MODE_FLAG) begin
                    nx.pin_out[i] = nx.flag[i];
                end else begin
                    nx.pin_out[i] = src_of(nx.mode[i], sel_ref, nx.div2, nx.div4[1]);
                end
            end

            nx.ref_out = clocks_on && sel_ref;
            nx.synth_on = synth_enable_pin;
            nx.ref_se = synth_enable_pin && ref_select_pin;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
            st.ctrl <= CTRL_RESET;
            st.overrange_threshold <= THRESH_RESET;
            st.overrange_min_hold <= HOLD_RESET;
            st.wait_req <= 1'b1;
            st.rdata <= RDATA_RESET;
            st.mode[CH_C] <= MODE_FLAG;
            st.mode[CH_D] <= MODE_FLAG;
        end else begin
            st <= nx;
        end
    end

    assign avs_readdata = st.rdata;
    assign avs_waitrequest = st.wait_req;
    assign status_out_c = st.pin_out[CH_C];
    assign status_out_d = st.pin_out[CH_D];
    assign ref_repeat_out = st.ref_out;
    assign synth_active = st.synth_on;
    assign synth_ref_single_ended = st.ref_se;

    // ==========================================================================
    // Assertions
    // ==========================================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_flag_d_stays;
        ce && st.mode[CH_D] == MODE_FLAG && nx.mode[CH_D] == MODE_FLAG && !power_down_pin;
    endsequence

    sequence s_flag_c_rises;
        $rose(st.flag[CH_C]) && st.overrange_min_hold >= HOLD_W'(2) && !power_down_pin;
    endsequence

    a_flag_d_out: assert property (s_flag_d_stays |=> status_out_d == st.flag[CH_D])
        else $error("channel D pin does not show its over-range flag");
    a_exceed_sets: assert property (ce && exceed[CH_D] && !power_down_pin
                                    |=> st.flag[CH_D])
        else $error("over-range flag not set by exceeding sample");
    a_hold_min: assert property (s_flag_c_rises |-> st.flag[CH_C] [*2])
        else $error("over-range flag shorter than minimum hold");
    a_cfg_low_flag: assert property (clkout_cfg_pins == 2'b00 &&
                                     !st.ctrl[CTRL_OVERRIDE_BIT]
                                     |-> target[CH_D] == MODE_FLAG)
        else $error("channel D not routed to flag with straps low");
    a_strap_div1: assert property (ce && st.mode[CH_D] == MODE_DIV1 &&
                                   nx.mode[CH_D] == MODE_DIV1 && !power_down_pin
                                   |=> status_out_d == $past(sel_ref))
        else $error("channel D does not copy the reference");
    a_divide_override: assert property (target[CH_D] inside {MODE_DIV2, MODE_DIV4}
                                        |-> st.ctrl[CTRL_OVERRIDE_BIT])
        else $error("channel D divided clock without override");
    a_d_needs_c: assert property (st.mode[CH_D] != MODE_FLAG
                                  |-> st.mode[CH_C] != MODE_FLAG)
        else $error("channel D clocks while channel C does not");
    a_pd_stops: assert property (ce && power_down_pin
                                 |=> !ref_repeat_out && !status_out_c && !status_out_d)
        else $error("clocks still running in power-down");
    a_synth_follow: assert property (ce |=> synth_active == $past(synth_enable_pin))
        else $error("synthesizer enable not followed");
    a_diff_only: assert property (ce && !synth_enable_pin
                                  |=> !synth_ref_single_ended)
        else $error("single-ended reference used with synthesizer off");
    a_repeat_copy: assert property (ce && clocks_on
                                    |=> ref_repeat_out == $past(sel_ref))
        else $error("repeat output does not copy the selected reference");
    a_c_div2: assert property (ce && st.mode[CH_C] == MODE_DIV2 &&
                               nx.mode[CH_C] == MODE_DIV2 && !power_down_pin
                               |=> status_out_c == st.div2)
        else $error("channel C half-rate copy wrong");
    a_c_div4: assert property (ce && st.mode[CH_C] == MODE_DIV4 &&
                               nx.mode[CH_C] == MODE_DIV4 && !power_down_pin
                               |=> status_out_c == st.div4[1])
        else $error("channel C quarter-rate copy wrong");
    a_glitch_free: assert property ($changed(st.mode[CH_C]) |-> !$past(status_out_c))
        else $error("channel C mode changed while its pin was high");
    a_glitch_free_d: assert property ($changed(st.mode[CH_D]) |-> !$past(status_out_d))
        else $error("channel D mode changed while its pin was high");
    // A frozen block must not drift, or a clock pin could stretch or cut a phase.
    a_ce_freeze: assert property (!ce |=> $stable(st))
        else $error("state changed while clock enable was low");

endmodule // ref_clock_out_routing

`default_nettype wire

// >>> logic/clkout_routing_pkg.sv
// Purpose: Shared constants and types for the reference clock and status pin routing block.
// Assumes: Byte addresses on a 32-bit Avalon-MM register port.
// Notes: Pin mode codes match the clock-output configuration codes.
`default_nettype none

package clkout_routing_pkg;

    // ==========================================================================
    // Widths
    // ==========================================================================
    localparam int unsigned SAMPLE_W = 12;
    localparam int unsigned HOLD_W = 8;
    localparam int unsigned CTRL_W = 6;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CHANNELS = 2;
    localparam int unsigned CH_C = 0;
    localparam int unsigned CH_D = 1;

    // ==========================================================================
    // Register map
    // ==========================================================================
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_THRESH = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_HOLD = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'hC;

    localparam int unsigned CTRL_OVERRIDE_BIT = 0;
    localparam int unsigned CTRL_CFG_C_LSB = 1;
    localparam int unsigned CTRL_CFG_D_LSB = 3;
    localparam int unsigned CTRL_DISABLE_BIT = 5;

    localparam int unsigned STAT_FLAG_LSB = 0;
    localparam int unsigned STAT_MODE_C_LSB = 2;
    localparam int unsigned STAT_MODE_D_LSB = 4;
    localparam int unsigned STAT_PLL_BIT = 6;

    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
    localparam logic [SAMPLE_W-1:0] THRESH_RESET = 12'h800;
    localparam logic [HOLD_W-1:0] HOLD_RESET = 8'h01;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

    // ==========================================================================
    // Status pin modes
    // ==========================================================================
    typedef enum logic [1:0] {
        MODE_FLAG = 2'b00,
        MODE_DIV1 = 2'b01,
        MODE_DIV2 = 2'b10,
        MODE_DIV4 = 2'b11
    } pin_mode_t;

endpackage

`default_nettype wire

// >>> tb/clock_consumer.sv
// Purpose: Far-side consumer of the repeat output and the C and D status pins.
// Assumes: Pins are sampled on ref_clk, so a high run is counted in whole cycles.
// Notes: clr restarts the counts; a high run already under way at clr is not measured.
`timescale 1ns/1ps
`default_nettype none

module clock_consumer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic [2:0] clk_in,
    output logic [2:0][15:0] edges,
    output logic [2:0][7:0] min_high
);
    // ==========================================================================
    // Edge counter and shortest high pulse
    // ==========================================================================
    logic [2:0] prev;
    logic [2:0] armed;
    logic [2:0][7:0] run;

    // A run cut by clr is skipped, so a clear in mid-pulse never reads as a runt.
    always_ff @(posedge clk or negedge rst_n) begin
        for (int i = 0; i < 3; i++) begin
            if (!rst_n || clr) begin
                edges[i] <= '0;
                min_high[i] <= 8'hFF;
                run[i] <= '0;
                armed[i] <= !clk_in[i];
                prev[i] <= clk_in[i];
            end else begin
                prev[i] <= clk_in[i];
                if (clk_in[i] && !prev[i]) begin
                    edges[i] <= edges[i] + 16'h0001;
                end
                if (clk_in[i]) begin
                    run[i] <= run[i] + 8'h01;
                end else begin
                    if (prev[i] && armed[i] && run[i] < min_high[i]) begin
                        min_high[i] <= run[i];
                    end
                    armed[i] <= 1'b1;
                    run[i] <= '0;
                end
            end
        end
    end
endmodule // clock_consumer

`default_nettype wire

// >>> tb/ref_clock_out_routing_tb_top.sv
// Purpose: Self-checking bench for ref_clock_out_routing.
// Assumes: Differential ref has a 2-cycle period, single-ended ref a 4-cycle period.
// Notes: Clock pins are judged by rising-edge counts over a 64-cycle window.
`timescale 1ns/1ps
`default_nettype none

module ref_clock_out_routing_tb_top;
    import clkout_routing_pkg::*;

    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic diff_ref_in = 1'b0;
    logic single_ended_ref_in = 1'b0;
    logic [1:0] ph = 2'b00;
    logic ref_select_pin = 1'b0;
    logic synth_enable_pin = 1'b0;
    logic power_down_pin = 1'b0;
    logic [1:0] clkout_cfg_pins = 2'b00;
    logic [SAMPLE_W-1:0] sample_c = '0;
    logic [SAMPLE_W-1:0] sample_d = '0;
    logic status_out_c, status_out_d, ref_repeat_out, synth_active, synth_ref_single_ended;
    logic clr = 1'b0;
    logic [2:0][15:0] edges;
    logic [2:0][7:0] min_high;
    logic [DATA_W-1:0] q;
    int n_errors = 0;
    int checked = 0;

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        diff_ref_in <= ~diff_ref_in;
        ph <= ph + 2'b01;
        single_ended_ref_in <= ph[1];
    end

    ref_clock_out_routing i_ref_clock_out_routing (.ref_clk, .arst_n, .ce, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .diff_ref_in,
        .single_ended_ref_in, .ref_select_pin, .synth_enable_pin, .power_down_pin,
        .clkout_cfg_pins, .sample_c, .sample_d, .status_out_c, .status_out_d,
        .ref_repeat_out, .synth_active, .synth_ref_single_ended);

    clock_consumer i_clock_consumer (.clk(ref_clk), .rst_n(arst_n), .clr(clr),
        .clk_in({status_out_d, status_out_c, ref_repeat_out}), .edges(edges),
        .min_high(min_high));

    // ==========================================================================
    // Tasks
    // ==========================================================================
    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rng(input string nm, input int lo, input int hi, input int got);
        checked++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask

    // The request stands until waitrequest is sampled low; data is taken at that edge.
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int i;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        for (i = 0; i < 40; i++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (i == 40) begin
            n_errors++;
            $display("unexpected bus timeout");
            test_done();
        end
    endtask

    task automatic rd(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        bus(1'b0, a, '0);
        chk(nm, exp, q);
    endtask

    // Settling time first, because mode changes wait for the pins to go low.
    task automatic measure;
        repeat (16) @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        repeat (64) @(posedge ref_clk);
    endtask

    task automatic ex(input string nm, input int idx, input int exp);
        rng(nm, (exp == 0) ? 0 : exp - 1, (exp == 0) ? 0 : exp + 1, int'(edges[idx]));
    endtask

    task automatic pulse(input logic on_d, input logic [SAMPLE_W-1:0] v);
        @(posedge ref_clk);
        clr <= 1'b1;
        if (on_d) sample_d <= v;
        else sample_c <= v;
        @(posedge ref_clk);
        clr <= 1'b0;
        sample_c <= '0;
        sample_d <= '0;
        repeat (20) @(posedge ref_clk);
    endtask

    // ==========================================================================
    // Sequence
    // ==========================================================================
    initial begin
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd("ctrl", ADDR_CTRL, 32'h0000_0000);
        rd("thresh", ADDR_THRESH, 32'h0000_0800);
        rd("hold", ADDR_HOLD, 32'h0000_0001);
        bus(1'b1, 4'h1, 32'hFFFF_FFFF);
        rd("unmapped", 4'h1, 32'h0000_0000);
        synth_enable_pin <= 1'b1;
        ref_select_pin <= 1'b1;
        measure();
        ex("repeat single", 0, 16);
        chk("ref single", 1, synth_ref_single_ended);
        ref_select_pin <= 1'b0;
        measure();
        ex("repeat diff", 0, 32);
        synth_enable_pin <= 1'b0;
        ref_select_pin <= 1'b1;
        measure();
        ex("repeat off", 0, 0);
        chk("synth off", 0, synth_active);
        chk("ref when off", 0, synth_ref_single_ended);
        synth_enable_pin <= 1'b1;
        ref_select_pin <= 1'b0;
        for (int s = 1; s < 4; s++) begin
            clkout_cfg_pins <= 2'(s);
            measure();
            ex("strap c", 1, 32 >> (s - 1));
            ex("strap d", 2, 32);
        end
        chk("synth on", 1, synth_active);
        ce <= 1'b0;
        synth_enable_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk("frozen synth", 1, synth_active);
        ce <= 1'b1;
        synth_enable_pin <= 1'b1;
        bus(1'b1, ADDR_CTRL, 32'h0000_0020);
        measure();
        ex("disabled d", 2, 0);
        bus(1'b1, ADDR_CTRL, 32'h0000_0000);
        power_down_pin <= 1'b1;
        measure();
        ex("pd repeat", 0, 0);
        ex("pd c", 1, 0);
        ex("pd d", 2, 0);
        power_down_pin <= 1'b0;
        for (int c = 1; c < 4; c++) begin
            bus(1'b1, ADDR_CTRL, 32'(1 + (c << 1) + (2 << 3)));
            bus(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
            measure();
            ex("override c", 1, 32 >> (c - 1));
            ex("override d half", 2, 16);
            bus(1'b0, ADDR_STATUS, '0);
            chk("mode c", 32'(c), {30'h0, q[3:2]});
        end
        bus(1'b1, ADDR_CTRL, 32'h0000_0009);
        measure();
        ex("d without c", 2, 0);
        bus(1'b1, ADDR_CTRL, 32'h0000_0007);
        measure();
        bus(1'b1, ADDR_CTRL, 32'h0000_0005);
        repeat (64) @(posedge ref_clk);
        rng("ratio change pulse", 2, 4, int'(min_high[1]));
        bus(1'b1, ADDR_CTRL, 32'h0000_0000);
        clkout_cfg_pins <= 2'b00;
        bus(1'b1, ADDR_HOLD, 32'h0000_0005);
        bus(1'b1, ADDR_THRESH, 32'h0000_0100);
        repeat (16) @(posedge ref_clk);
        pulse(1'b1, 12'h100);
        ex("flag d equal", 2, 0);
        pulse(1'b1, 12'h101);
        rng("flag d count", 1, 1, int'(edges[2]));
        rng("flag d hold", 5, 7, int'(min_high[2]));
        pulse(1'b0, 12'hFFF);
        rng("flag c hold", 5, 7, int'(min_high[1]));
        test_done();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        $display("unexpected run timeout");
        test_done();
    end
endmodule // ref_clock_out_routing_tb_top

`default_nettype wire
